// *** design/mcr_pkg.sv ***
package mcr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses on the register bus)
   localparam logic [15:0] MCR_OFS_CFG_ONE = 16'hDF0F;
   localparam logic [15:0] MCR_OFS_CFG_ZERO = 16'hDF10;
   localparam logic [15:0] MCR_OFS_DEV = 16'hDF11;
   localparam logic [15:0] MCR_OFS_CHANNEL_NUMBER = 16'hDF20;
   localparam logic [15:0] MCR_OFS_DEV_M = 16'hDF21;
   localparam logic [15:0] MCR_OFS_SPACING = 16'hDF24;
   localparam logic [15:0] MCR_OFS_OFFSET = 16'hDF28;
   localparam logic [15:0] MCR_OFS_DEVIATION = 16'hDF2C;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int MCR_FEC_BIT = 7;
   localparam int MCR_PRE_LSB = 4;
   localparam int MCR_SPC_E_LSB = 0;
   localparam int MCR_DEV_E_LSB = 4;
   localparam int MCR_DEV_M_LSB = 0;

   // writable masks; everything else reads zero
   localparam logic [7:0] MCR_MASK_CFG_ONE = 8'hF3;
   localparam logic [7:0] MCR_MASK_DEV = 8'h77;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] MCR_RST_CFG_ONE = 8'h22;
   localparam logic [7:0] MCR_RST_CFG_ZERO = 8'hF8;
   localparam logic [7:0] MCR_RST_DEV = 8'h47;
   localparam logic [7:0] MCR_RST_CHANNEL_NUMBER = 8'h00;

   // spacing and deviation fractional shifts (divide by 2^18, 2^17)
   localparam int MCR_SPC_SHIFT = 18;
   localparam int MCR_DEV_SHIFT = 17;
   localparam logic [8:0] MCR_SPC_ONE = 9'h100;
   localparam logic [3:0] MCR_DEV_ONE = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic error_correction_enable;
      logic [2:0] preamble_count;
      logic [4:0] preamble_bytes;
      logic [1:0] channel_spacing_exponent;
      logic [7:0] channel_spacing_mantissa;
      logic [2:0] deviation_exponent;
      logic [2:0] deviation_mantissa;
      logic [7:0] channel_number;
   } mcr_cfg_s;

   typedef enum logic [1:0] {
      MCR_IDLE = 2'b00,
      MCR_ANSWER = 2'b01,
      MCR_DONE = 2'b10
   } mcr_state_e;

   // minimum preamble bytes per code
   function automatic logic [4:0] mcr_preamble_bytes(input logic [2:0] code);
      case (code)
         3'h0: return 5'h02;
         3'h1: return 5'h03;
         3'h2: return 5'h04;
         3'h3: return 5'h06;
         3'h4: return 5'h08;
         3'h5: return 5'h0C;
         3'h6: return 5'h10;
         default: return 5'h18;
      endcase
   endfunction : mcr_preamble_bytes

endpackage : mcr_pkg

// *** design/mcr_freq_calc.sv ***
`timescale 1ns/100ps
`default_nettype none
// frequency words in units of f_ref / 2^18 (spacing, offset) and f_ref / 2^17 (deviation)
module mcr_freq_calc
   import mcr_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst_n, // sync reset, active low
   input wire mcr_cfg_s cfg, // decoded settings
   output logic [11:0] spacing_q, // (256+m) << e
   output logic [19:0] offset_q, // spacing * channel
   output logic [10:0] deviation_q // (8+m) << e
);

   ////////////////////////////////////////////////////////////////////////////
   logic [11:0] spacing_d;
   logic [19:0] offset_d;
   logic [10:0] deviation_d;

   assign spacing_d = 12'({MCR_SPC_ONE | {1'b0, cfg.channel_spacing_mantissa}})
                      << cfg.channel_spacing_exponent;
   // unsigned product added to base frequency downstream
   // widen both factors first; a cast around the product would keep only 12 bits of it
   assign offset_d = 20'(spacing_d) * 20'(cfg.channel_number);
   assign deviation_d = 11'({MCR_DEV_ONE | {1'b0, cfg.deviation_mantissa}})
                        << cfg.deviation_exponent;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         spacing_q <= '0;
         offset_q <= '0;
         deviation_q <= '0;
      end else begin
         spacing_q <= spacing_d;
         offset_q <= offset_d;
         deviation_q <= deviation_d;
      end
   end

endmodule : mcr_freq_calc
`default_nettype wire

// *** design/mcr_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module mcr_regs
   import mcr_pkg::*;
(
   input wire logic ref_clk, // system clock, 100 MHz
   input wire logic rst_n, // sync reset, active low
   input wire logic [15:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   output logic [1:0] avs_response, // 00 okay, 10 slave error
   input wire logic tx_symbol, // data symbol being modulated
   output logic error_correction_enable, // payload fec + interleave
   output logic [4:0] preamble_bytes, // minimum preamble count
   output logic [11:0] spacing_word, // units fref/2^18
   output logic [19:0] offset_word, // units fref/2^18
   output logic [10:0] deviation_word, // units fref/2^17
   output logic [11:0] tx_deviation, // signed deviation per symbol
   output mcr_cfg_s cfg_q // all decoded settings
);

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] cfg_one_q, cfg_one_d;
   logic [7:0] cfg_zero_q, cfg_zero_d;
   logic [7:0] dev_q, dev_d;
   logic [7:0] channel_number_q, channel_number_d;
   mcr_state_e state_q, state_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] resp_q, resp_d;
   logic wait_q;
   mcr_cfg_s cfg_d;
   logic fec_q, fec_d;
   logic [4:0] pre_q;
   logic [11:0] txdev_q, txdev_d;
   logic [11:0] spacing_w;
   logic [19:0] offset_w;
   logic [10:0] deviation_w;

   ////////////////////////////////////////////////////////////////////////////
   // decode; narrow registers live in lane 0 only
   wire hit_one = avs_address == MCR_OFS_CFG_ONE;
   wire hit_zero = avs_address == MCR_OFS_CFG_ZERO;
   wire hit_dev = avs_address == MCR_OFS_DEV;
   wire hit_channel_number = avs_address == MCR_OFS_CHANNEL_NUMBER;
   wire hit_spc = avs_address == MCR_OFS_SPACING;
   wire hit_ofs = avs_address == MCR_OFS_OFFSET;
   wire hit_dvw = avs_address == MCR_OFS_DEVIATION;
   wire hit_any = hit_one | hit_zero | hit_dev | hit_channel_number | hit_spc | hit_ofs | hit_dvw;
   wire take = (avs_read | avs_write) & (state_q == MCR_IDLE);
   wire wr_en = take & avs_write & avs_byteenable[0];
   wire [7:0] wb = avs_writedata[7:0];

   assign cfg_one_d = (wr_en & hit_one) ? (wb & MCR_MASK_CFG_ONE) : cfg_one_q;
   assign cfg_zero_d = (wr_en & hit_zero) ? wb : cfg_zero_q;
   assign dev_d = (wr_en & hit_dev) ? (wb & MCR_MASK_DEV) : dev_q;
   assign channel_number_d = (wr_en & hit_channel_number) ? wb : channel_number_q;

   assign rdata_d = hit_one ? {24'h000000, cfg_one_q} :
                    hit_zero ? {24'h000000, cfg_zero_q} :
                    hit_dev ? {24'h000000, dev_q} :
                    hit_channel_number ? {24'h000000, channel_number_q} :
                    hit_spc ? {20'h00000, spacing_w} :
                    hit_ofs ? {12'h000, offset_w} :
                    hit_dvw ? {21'h00000, deviation_w} : 32'h00000000;
   // writes to the read-only computed words are refused as errors
   assign resp_d = (!hit_any || (avs_write && (hit_spc || hit_ofs || hit_dvw))) ? 2'h2 : 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // field extraction
   assign cfg_d.error_correction_enable = cfg_one_q[MCR_FEC_BIT];
   assign cfg_d.preamble_count = cfg_one_q[MCR_PRE_LSB +: 3];
   assign cfg_d.preamble_bytes = mcr_preamble_bytes(cfg_one_q[MCR_PRE_LSB +: 3]);
   assign cfg_d.channel_spacing_exponent = cfg_one_q[MCR_SPC_E_LSB +: 2];
   assign cfg_d.channel_spacing_mantissa = cfg_zero_q;
   assign cfg_d.deviation_exponent = dev_q[MCR_DEV_E_LSB +: 3];
   assign cfg_d.deviation_mantissa = dev_q[MCR_DEV_M_LSB +: 3];
   assign cfg_d.channel_number = channel_number_q;
   // fec is honoured as written; fixed-length framing is software's duty
   assign fec_d = cfg_one_q[MCR_FEC_BIT];
   // symbol 0 pulls below carrier, symbol 1 above
   assign txdev_d = tx_symbol ? {1'b0, deviation_w} : 12'(-{1'b0, deviation_w});

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: idle -> answer (waitrequest low one cycle) -> done
   always_comb begin
      state_d = state_q;
      case (state_q)
         MCR_IDLE: if (avs_read | avs_write) state_d = MCR_ANSWER;
         MCR_ANSWER: state_d = MCR_DONE;
         MCR_DONE: state_d = MCR_IDLE;
         default: state_d = MCR_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   mcr_freq_calc u_calc (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .cfg(cfg_q),
      .spacing_q(spacing_w),
      .offset_q(offset_w),
      .deviation_q(deviation_w)
   );

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cfg_one_q <= MCR_RST_CFG_ONE;
         cfg_zero_q <= MCR_RST_CFG_ZERO;
         dev_q <= MCR_RST_DEV;
         channel_number_q <= MCR_RST_CHANNEL_NUMBER;
         state_q <= MCR_IDLE;
         rdata_q <= '0;
         resp_q <= '0;
         wait_q <= 1'b1;
      end else begin
         cfg_one_q <= cfg_one_d;
         cfg_zero_q <= cfg_zero_d;
         dev_q <= dev_d;
         channel_number_q <= channel_number_d;
         state_q <= state_d;
         if (take) begin
            rdata_q <= rdata_d;
            resp_q <= resp_d;
         end
         wait_q <= !(state_d == MCR_ANSWER);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cfg_q <= '0;
         fec_q <= 1'b0;
         pre_q <= '0;
         txdev_q <= '0;
      end else begin
         cfg_q <= cfg_d;
         fec_q <= fec_d;
         pre_q <= cfg_d.preamble_bytes;
         txdev_q <= txdev_d;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign avs_response = resp_q;
   assign error_correction_enable = fec_q;
   assign preamble_bytes = pre_q;
   assign spacing_word = spacing_w;
   assign offset_word = offset_w;
   assign deviation_word = deviation_w;
   assign tx_deviation = txdev_q;

endmodule : mcr_regs
`default_nettype wire

// *** sim/mcr_regs_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module mcr_regs_sva
   import mcr_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst_n, // reset
   input wire logic [15:0] avs_address, // bus
   input wire logic avs_read, // bus
   input wire logic avs_write, // bus
   input wire logic [31:0] avs_writedata, // bus
   input wire logic [31:0] avs_readdata, // bus
   input wire logic avs_waitrequest, // bus
   input wire logic [1:0] avs_response, // bus
   input wire logic tx_symbol, // datapath
   input wire logic error_correction_enable, // out
   input wire logic [11:0] spacing_word, // out
   input wire logic [19:0] offset_word, // out
   input wire logic [10:0] deviation_word, // out
   input wire logic [11:0] tx_deviation, // out
   input wire mcr_cfg_s cfg_q // out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // derived words lag the settings by a few edges
   sequence s_calm; $stable(cfg_q) [*5]; endsequence
   sequence s_acc; !avs_waitrequest && avs_read; endsequence
   // completed write to config one, seen at the edge that ends the access
   wire logic wr_one = avs_write && !avs_waitrequest && avs_address == MCR_OFS_CFG_ONE;
   property p_wait_one; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low too long");
   property p_fec_wr; avs_write && !avs_waitrequest && avs_address == MCR_OFS_CFG_ONE
      |-> ##2 error_correction_enable == $past(avs_writedata[7], 2); endproperty
   a_fec_wr: assert property (p_fec_wr) else $error("fec not written");
   // the enable may only move one edge after a write to config one completes
   property p_fec; $changed(error_correction_enable) |-> $past(wr_one); endproperty
   a_fec: assert property (p_fec) else $error("fec level");
   property p_spc; s_calm |-> spacing_word ==
      ({3'h0, 1'b1, cfg_q.channel_spacing_mantissa} << cfg_q.channel_spacing_exponent);
   endproperty
   a_spc: assert property (p_spc) else $error("spacing word");
   property p_off; s_calm |-> offset_word == spacing_word * cfg_q.channel_number; endproperty
   a_off: assert property (p_off) else $error("offset word");
   property p_dev; s_calm |-> deviation_word ==
      ({7'h00, 1'b1, cfg_q.deviation_mantissa} << cfg_q.deviation_exponent); endproperty
   a_dev: assert property (p_dev) else $error("deviation word");
   property p_txdev; $stable(deviation_word) |=> tx_deviation == ($past(tx_symbol) ?
      {1'b0, $past(deviation_word)} : -{1'b0, $past(deviation_word)}); endproperty
   a_txdev: assert property (p_txdev) else $error("tx deviation sign");
   property p_bad; s_acc and avs_address == MCR_OFS_DEV_M
      |-> avs_response == 2'b10 && avs_readdata == 32'h0; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read");
   property p_rsvd; s_acc and avs_address == MCR_OFS_DEV
      |-> (avs_readdata & 32'hFFFFFF88) == 32'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("unused bits set");
endmodule : mcr_regs_sva
bind mcr_regs mcr_regs_sva i_mcr_regs_sva (.ref_clk, .rst_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .avs_response, .tx_symbol,
   .error_correction_enable, .spacing_word, .offset_word, .deviation_word, .tx_deviation,
   .cfg_q);
`default_nettype wire

// *** sim/mcr_dp_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module mcr_dp_model (
   input wire logic ref_clk, // clock
   input wire logic rst_n, // reset
   output logic tx_symbol // symbol being sent
);
   logic [2:0] pat_q;
   // 110 pattern so both deviation signs occur, also back to back
   always_ff @(posedge ref_clk) begin
      if (!rst_n) pat_q <= 3'h6;
      else pat_q <= {pat_q[1:0], pat_q[2]};
   end
   assign tx_symbol = pat_q[2];
endmodule : mcr_dp_model
`default_nettype wire

// *** sim/mcr_regs_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module mcr_regs_test
   import mcr_pkg::*;
;
   logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, tx_symbol, fec;
   logic [15:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [1:0] avs_response, r;
   logic [4:0] preamble_bytes;
   logic [11:0] spacing_word, tx_deviation;
   logic [19:0] offset_word;
   logic [10:0] deviation_word;
   mcr_cfg_s cfg_q;
   int err_count, cmp_count;
   mcr_regs i_mcr_regs (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest,
      .avs_response, .tx_symbol, .error_correction_enable(fec), .preamble_bytes,
      .spacing_word, .offset_word, .deviation_word, .tx_deviation, .cfg_q);
   mcr_dp_model i_mcr_dp_model (.ref_clk, .rst_n, .tx_symbol);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      r = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // let an edge pass so a following call never re-drives the strobes in this step
      @(posedge ref_clk);
      if (n >= 40) chk(32'h1, 32'h0);
   endtask : bus
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rd
   // derived words settle within three edges of a write
   task automatic settle;
      repeat (5) @(posedge ref_clk);
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(MCR_OFS_CFG_ONE, 32'h22);
      rd(MCR_OFS_CFG_ZERO, 32'hF8);
      rd(MCR_OFS_DEV, 32'h47);
      chk(32'(fec), 32'h0);
      chk(32'(preamble_bytes), 32'h4);
      chk(32'(spacing_word), 32'h7E0);
      chk(32'(offset_word), 32'h0);
      chk(32'(deviation_word), 32'hF0);
   endtask : t_reset
   task automatic t_preamble;
      logic [4:0] tbl [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, MCR_OFS_CFG_ONE, {1'b1, 3'(c), 4'hF});
         settle();
         rd(MCR_OFS_CFG_ONE, {24'h0, 1'b1, 3'(c), 4'h3});
         chk(32'(preamble_bytes), 32'(tbl[c]));
         chk(32'(fec), 32'h1);
      end
   endtask : t_preamble
   task automatic t_spacing;
      logic [11:0] s;
      logic [7:0] m;
      bus(1'b1, MCR_OFS_CHANNEL_NUMBER, 8'hFF);
      for (int k = 0; k < 8; k++) begin
         m = k[2] ? 8'hFF : 8'h00;
         bus(1'b1, MCR_OFS_CFG_ONE, {6'h00, 2'(k)});
         bus(1'b1, MCR_OFS_CFG_ZERO, m);
         settle();
         s = (12'h100 + 12'(m)) << k[1:0];
         chk(32'(spacing_word), 32'(s));
         chk(32'(offset_word), 32'(s) * 32'd255);
      end
   endtask : t_spacing
   task automatic t_dev;
      bus(1'b1, MCR_OFS_DEV, 8'hFF);
      settle();
      rd(MCR_OFS_DEV, 32'h77);
      chk(32'(deviation_word), 32'h780);
      bus(1'b1, MCR_OFS_DEV, 8'h08);
      settle();
      rd(MCR_OFS_DEV, 32'h0);
      chk(32'(deviation_word), 32'h8);
      rd(MCR_OFS_DEV_M, 32'h0);
      chk(32'(r), 32'h2);
      bus(1'b1, MCR_OFS_SPACING, 8'h00);
      chk(32'(r), 32'h2);
   endtask : t_dev
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   initial begin
      repeat (3000) @(posedge ref_clk);
      err_count++;
      close_out();
   end
   initial begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 16'h0000;
      avs_writedata = 32'h0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      settle();
      t_reset();
      t_preamble();
      t_spacing();
      t_dev();
      close_out();
   end
endmodule : mcr_regs_test
`default_nettype wire
